//--- hdl/mood_link_defs.svh
`ifndef MOOD_LINK_DEFS_SVH
`define MOOD_LINK_DEFS_SVH
// Timing figures in their own units, clock rate in MHz
`define CLOCK_MHZ           250
`define SOFT_START_US       200
`define OFF_TIMEOUT_US      500
`define LATCH_TIMEOUT_US    500
`define MIN_HIGH_NS         50
`define MIN_LOW_NS          300
`define MAX_EDGE_RATE_MHZ   1
// Cycle counts derived from the figures, then fixed constants
`define SOFT_START_CYC      (`SOFT_START_US * `CLOCK_MHZ)
`define OFF_TIMEOUT_CYC     (`OFF_TIMEOUT_US * `CLOCK_MHZ)
`define LATCH_TIMEOUT_CYC   (`LATCH_TIMEOUT_US * `CLOCK_MHZ)
`define MIN_HIGH_CYC        ((`MIN_HIGH_NS * `CLOCK_MHZ + 999) / 1000)
`define MIN_LOW_CYC         ((`MIN_LOW_NS * `CLOCK_MHZ + 999) / 1000)
`define EDGE_PERIOD_CYC     (`CLOCK_MHZ / `MAX_EDGE_RATE_MHZ)
`define RESYNC_LOW_CYC      (`OFF_TIMEOUT_CYC + 16'h0100)
`define MAX_EDGES           16
`define COLOURS             64
`define FLICKER_SEED        8'h5a
`define FULL_LEVEL          8'hff
`define FAST_STEP_CYC       250000
`define SLOW_STEP_CYC       1000000
`endif

//--- hdl/mood_link_pkg.sv
package mood_link_pkg;
   typedef enum logic [1:0] {
      mood_smooth_wheel  = 2'h0,
      mood_pulsing_tones = 2'h1,
      mood_varied_wheel  = 2'h2,
      mood_flicker_warm  = 2'h3
   } mood_t;
   typedef enum logic [1:0] {
      pump_1x  = 2'h0,
      pump_1p5 = 2'h1,
      pump_2x  = 2'h2
   } pump_mode_t;
   typedef enum logic [3:0] {
      dev_off   = 4'h1,
      dev_count = 4'h2,
      dev_run   = 4'h4,
      dev_spare = 4'h8
   } dev_state_t;
   typedef enum logic [4:0] {
      host_idle  = 5'h01,
      host_reset = 5'h02,
      host_high  = 5'h04,
      host_low   = 5'h08,
      host_hold  = 5'h10
   } host_state_t;
endpackage

//--- hdl/mood_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mood_link_if;
   logic enable_set;
   modport host (output enable_set);
   modport device (input enable_set);
endinterface
`default_nettype wire

//--- hdl/mood_led_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "mood_link_defs.svh"
// How it works
// - Count 1..16 rising edges, pick setting
// - First edge wakes, starts pump soft-start
// - Edges still counted during soft-start
// - Edge counter handles up to 1 MHz
// - Host holds high 50 ns, low 0.3-75 us
// - Line high for latch timeout latches count
// - Low for off timeout clears everything
// - High after latch keeps current and mood
// - Count decodes brightness, pace, mood
// - Dimmed level is 6 dB below full
// - Cycle 64 colours at chosen pace
// - Four preset colour patterns
// - Pump 1X, then 1.5X, then 2X on droop
// - Host sends long low before each burst
module mood_led_device
   import mood_link_pkg::*;
#(
   parameter int unsigned OFF_CYC   = `OFF_TIMEOUT_CYC,
   parameter int unsigned LATCH_CYC = `LATCH_TIMEOUT_CYC,
   parameter int unsigned SOFT_CYC  = `SOFT_START_CYC,
   parameter int unsigned FAST_CYC  = `FAST_STEP_CYC,
   parameter int unsigned SLOW_CYC  = `SLOW_STEP_CYC
) (
   input  wire logic      clock,
   input  wire logic      reset_n,
   mood_link_if.device    link,
   input  wire logic      near_dropout,
   output logic           enabled,
   output logic           pump_ready,
   output pump_mode_t     pump_mode,
   output logic           setting_valid,
   output logic [3:0]     setting,
   output mood_t          mood,
   output logic           dimmed,
   output logic           slow_pace,
   output logic [5:0]     colour_index,
   output logic [7:0]     current_source_one,
   output logic [7:0]     current_source_two,
   output logic [2:0]     led_rgb
);
   localparam int unsigned TW      = 20;
   localparam int unsigned SOURCES = 2;

   // Every timing count lives in a TW-bit counter and needs at least one cycle
   if (OFF_CYC < 1 || LATCH_CYC < 1 || OFF_CYC >= (1 << TW) ||
       LATCH_CYC >= (1 << TW)) begin : g_bad_timeout
      $error("mood_led_device: timeout parameter out of range");
   end
   if (SOFT_CYC < 1 || SOFT_CYC >= (1 << TW)) begin : g_bad_soft
      $error("mood_led_device: soft-start parameter out of range");
   end
   // The fast pace must not step slower than the slow one
   if (FAST_CYC < 1 || SLOW_CYC >= (1 << TW) || FAST_CYC > SLOW_CYC) begin : g_bad_pace
      $error("mood_led_device: pace parameter out of range");
   end

   // All state in one register, so a single clear covers everything
   typedef struct packed {
      dev_state_t     st;
      logic           line;
      logic [4:0]     edges;
      logic [TW-1:0]  level_cnt;
      logic [TW-1:0]  soft_cnt;
      logic           pump_rdy;
      pump_mode_t     pmode;
      logic           valid;
      logic [3:0]     code;
      logic [TW-1:0]  step_cnt;
      logic [5:0]     colour;
      logic [7:0]     lfsr;
      logic [7:0]     isrc;
      logic [2:0]     rgb;
   } dev_reg_t;

   // Off state; the flicker generator restarts from its seed on every wake
   localparam dev_reg_t CLEARED = '{st: dev_off, pmode: pump_1x, lfsr: `FLICKER_SEED,
                                    default: '0};

   dev_reg_t      r_q, r_d;
   logic          rise;
   logic [TW-1:0] step_lim;
   logic [7:0]    level;
   logic [1:0]    phase;
   logic [7:0]    drive [SOURCES];

   // single-cycle edge detect, far faster than 1 MHz
   assign rise = link.enable_set && !r_q.line;
   assign step_lim = r_q.code[2] ? TW'(SLOW_CYC) : TW'(FAST_CYC);

   always_comb begin
      r_d = r_q;
      r_d.line = link.enable_set;
      // One run-length counter serves both timeouts; it restarts on every change of level
      if (r_q.line == link.enable_set && r_q.level_cnt != {TW{1'b1}})
         r_d.level_cnt = r_q.level_cnt + TW'(1);
      else if (r_q.line != link.enable_set)
         r_d.level_cnt = '0;
      case (r_q.st)
         dev_off: begin
            if (rise) begin
               r_d.st = dev_count;
               r_d.edges = 5'h01;
               r_d.soft_cnt = '0;
               r_d.pump_rdy = 1'b0;
               r_d.pmode = pump_1x;
            end
         end
         dev_count, dev_run: begin
            // count during soft-start, saturate at 16
            // Saturating keeps a seventeenth edge from wrapping to the first setting
            if (rise && r_q.edges != 5'(`MAX_EDGES))
               r_d.edges = r_q.edges + 5'h01;
            // latch after line held high
            // A high shorter than the latch timeout is only a pulse of the burst
            if (r_q.line && link.enable_set && r_q.level_cnt == TW'(LATCH_CYC - 1)) begin
               r_d.st = dev_run;
               r_d.valid = 1'b1;
               r_d.code = 4'(r_q.edges - 5'h01);
               r_d.colour = '0;
               r_d.step_cnt = '0;
            end
            if (!r_q.line && !link.enable_set && r_q.level_cnt == TW'(OFF_CYC - 1))
               r_d = CLEARED;
         end
         default: r_d = CLEARED;
      endcase
      // soft-start timer
      // It runs alongside counting, so edges are never held off
      if (r_d.st != dev_off && !r_q.pump_rdy) begin
         if (r_q.soft_cnt == TW'(SOFT_CYC - 1))
            r_d.pump_rdy = 1'b1;
         else
            r_d.soft_cnt = r_q.soft_cnt + TW'(1);
      end
      // pump steps up on dropout, never back within a session
      // Dropout sense is ignored until soft-start has finished
      if (r_q.pump_rdy && r_d.st != dev_off && near_dropout) begin
         if (r_q.pmode == pump_1x)
            r_d.pmode = pump_1p5;
         else
            r_d.pmode = pump_2x;
      end
      // advance through 64 colours while running
      if (r_q.st == dev_run && r_d.st == dev_run) begin
         if (r_q.step_cnt >= step_lim - TW'(1)) begin
            r_d.step_cnt = '0;
            r_d.colour = r_q.colour + 6'h01;
            r_d.lfsr = {r_q.lfsr[6:0], r_q.lfsr[7] ^ r_q.lfsr[5] ^ r_q.lfsr[4] ^ r_q.lfsr[3]};
         end else
            r_d.step_cnt = r_q.step_cnt + TW'(1);
      end
      // pattern per mood, shown through the colour switches only
      // Next-state fields, so the first running cycle already shows the new setting
      level = `FULL_LEVEL;
      phase = r_d.colour[5:4];
      r_d.rgb = 3'h0;
      case (mood_t'(r_d.code[1:0]))
         mood_smooth_wheel: r_d.rgb = 3'(3'h1 + {1'b0, r_d.colour[5:4]} + 3'(r_d.colour[3]));
         mood_pulsing_tones: r_d.rgb = (phase == 2'h0) ? 3'h1 : (phase == 2'h2) ? 3'h4 : 3'h7;
         mood_varied_wheel: r_d.rgb = 3'(3'h1 + {1'b0, r_d.colour[5:4]} + 3'(r_d.colour[1]));
         mood_flicker_warm: r_d.rgb = r_d.lfsr[0] ? 3'h6 : 3'h4;
         default: r_d.rgb = 3'h0;
      endcase
      // 6 dB dim halves the current
      // Level stays fixed per brightness, whatever the mood does
      if (r_d.code[3])
         level = {1'b0, level[7:1]};
      r_d.isrc = (r_d.st == dev_run) ? level : 8'h00;
      if (r_d.st != dev_run)
         r_d.rgb = 3'h0;
   end

   always_ff @(posedge clock) begin
      if (!reset_n)
         r_q <= CLEARED;
      else
         r_q <= r_d;
   end

   // Level outputs decode straight from the state register
   assign enabled = (r_q.st != dev_off);
   assign pump_ready = r_q.pump_rdy;
   assign pump_mode = r_q.pmode;
   assign setting_valid = r_q.valid;
   assign setting = r_q.code;
   assign mood = mood_t'(r_q.code[1:0]);
   assign dimmed = r_q.code[3];
   assign slow_pace = r_q.code[2];
   assign colour_index = r_q.colour;

   // Both sources carry one level so the two LEDs stay matched
   for (genvar g = 0; g < SOURCES; g++) begin : g_source
      assign drive[g] = r_q.isrc;
   end
   assign current_source_one = drive[0];
   assign current_source_two = drive[1];
   assign led_rgb = r_q.rgb;
endmodule
`default_nettype wire

//--- hdl/mood_led_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "mood_link_defs.svh"
module mood_led_host
   import mood_link_pkg::*;
#(
   parameter int unsigned RESYNC_CYC = `RESYNC_LOW_CYC,
   parameter int unsigned LATCH_CYC  = `LATCH_TIMEOUT_CYC
) (
   input  wire logic        clock,
   input  wire logic        reset_n,
   mood_link_if.host        link,
   input  wire logic        send_valid,
   input  wire logic [3:0]  send_setting,
   output logic             send_ready,
   output logic             send_done
);
   localparam int unsigned TW = 20;
   localparam int unsigned HALF = `EDGE_PERIOD_CYC / 2;

   if (RESYNC_CYC < 1 || LATCH_CYC < 1 || RESYNC_CYC >= (1 << TW) ||
       LATCH_CYC >= (1 << TW) || HALF < `MIN_HIGH_CYC ||
       HALF < `MIN_LOW_CYC) begin : g_bad_timing
      $error("mood_led_host: timing parameter out of range");
   end

   typedef struct packed {
      host_state_t    st;
      logic           line;
      logic [4:0]     left;
      logic [TW-1:0]  cnt;
      logic           done;
   } host_reg_t;

   host_reg_t r_q, r_d;

   always_comb begin
      r_d = r_q;
      r_d.done = 1'b0;
      case (r_q.st)
         host_idle: begin
            if (send_valid) begin
               r_d.st = host_reset;
               r_d.line = 1'b0;
               r_d.left = 5'(send_setting) + 5'h01;
               r_d.cnt = '0;
            end
         end
         host_reset: begin
            r_d.cnt = r_q.cnt + TW'(1);
            if (r_q.cnt == TW'(RESYNC_CYC - 1)) begin
               r_d.st = host_high;
               r_d.line = 1'b1;
               r_d.left = r_q.left - 5'h01;
               r_d.cnt = '0;
            end
         end
         // half-period phases keep edges at 1 MHz
         host_high: begin
            r_d.cnt = r_q.cnt + TW'(1);
            if (r_q.cnt == TW'(HALF - 1)) begin
               r_d.cnt = '0;
               if (r_q.left == 5'h00)
                  r_d.st = host_hold;
               else begin
                  r_d.st = host_low;
                  r_d.line = 1'b0;
               end
            end
         end
         host_low: begin
            r_d.cnt = r_q.cnt + TW'(1);
            if (r_q.cnt == TW'(HALF - 1)) begin
               r_d.st = host_high;
               r_d.line = 1'b1;
               r_d.left = r_q.left - 5'h01;
               r_d.cnt = '0;
            end
         end
         host_hold: begin
            r_d.cnt = r_q.cnt + TW'(1);
            if (r_q.cnt == TW'(LATCH_CYC)) begin
               r_d.st = host_idle;
               r_d.done = 1'b1;
            end
         end
         default: r_d = '{st: host_idle, default: '0};
      endcase
   end

   always_ff @(posedge clock) begin
      if (!reset_n)
         r_q <= '{st: host_idle, default: '0};
      else
         r_q <= r_d;
   end

   assign link.enable_set = r_q.line;
   assign send_ready = (r_q.st == host_idle);
   assign send_done = r_q.done;
endmodule
`default_nettype wire

//--- tb/mood_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mood_link_sva
   import mood_link_pkg::*;
#(
   parameter int unsigned OFF_CYC   = 200,
   parameter int unsigned LATCH_CYC = 200,
   parameter int unsigned SOFT_CYC  = 20
) (
   input wire logic       clock,
   input wire logic       reset_n,
   input wire logic       enable_set,
   input wire logic       enabled,
   input wire logic       pump_ready,
   input wire pump_mode_t pump_mode,
   input wire logic       setting_valid,
   input wire logic [3:0] setting,
   input wire mood_t      mood,
   input wire logic       dimmed,
   input wire logic       slow_pace,
   input wire logic [5:0] colour_index,
   input wire logic [7:0] current_source_one,
   input wire logic [7:0] current_source_two
);
   logic [19:0] hi_q;
   logic [19:0] lo_q;
   logic [19:0] en_q;
   // Run lengths; 20 bits outlast any run of this bench, so no saturation
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         hi_q <= '0;
         lo_q <= '0;
         en_q <= '0;
      end else begin
         hi_q <= enable_set ? hi_q + 20'h1 : '0;
         lo_q <= enable_set ? '0 : lo_q + 20'h1;
         en_q <= enabled ? en_q + 20'h1 : '0;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   chk_latch_time: assert property ($rose(setting_valid) |->
      enable_set && hi_q >= LATCH_CYC - 1 && hi_q <= LATCH_CYC + 2)
      else $error("setting latched at wrong time");
   chk_latch_due: assert property (hi_q == LATCH_CYC + 3 |-> setting_valid)
      else $error("setting not latched after high hold");
   chk_off_clear: assert property (lo_q == OFF_CYC + 3 |-> !enabled &&
      !setting_valid && current_source_one == 8'h00 && pump_mode == pump_1x)
      else $error("not cleared after off timeout");
   chk_off_early: assert property ($fell(enabled) |-> !enable_set && lo_q >= OFF_CYC - 2)
      else $error("switched off too early");
   chk_wake_edge: assert property ($rose(enable_set) |-> ##[1:2] enabled)
      else $error("no wake on rising edge");
   chk_soft_early: assert property (pump_ready |-> enabled && en_q >= SOFT_CYC - 2)
      else $error("pump ready before soft start");
   chk_soft_due: assert property (en_q == SOFT_CYC + 3 |-> pump_ready)
      else $error("pump not ready after soft start");
   chk_run_hold: assert property (setting_valid && enable_set |=>
      setting_valid && $stable(setting))
      else $error("setting lost while line high");
   chk_decode_map: assert property (setting_valid |-> dimmed == setting[3] &&
      slow_pace == setting[2] && mood == setting[1:0])
      else $error("setting decode wrong");
   chk_dim_level: assert property (setting_valid && $past(setting_valid) |->
      current_source_one == current_source_two && (dimmed ?
      current_source_one inside {[8'h78:8'h80]} : current_source_one == 8'hff))
      else $error("drive level wrong");
   chk_colour_step: assert property ($changed(colour_index) && setting_valid &&
      $past(setting_valid) |-> colour_index == $past(colour_index) + 6'h1)
      else $error("colour index skipped");
   chk_pump_order: assert property ($changed(pump_mode) && enabled |->
      pump_mode == (($past(pump_mode) == pump_1x) ? pump_1p5 : pump_2x))
      else $error("pump mode order wrong");
   cover property ($rose(setting_valid) && dimmed && slow_pace);
   cover property ($rose(setting_valid) && !dimmed && !slow_pace);
   cover property (pump_mode == pump_2x);
   cover property ($fell(enabled));
endmodule
`default_nettype wire

//--- tb/pulse_count_mood_led_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_count_mood_led_controller_tb;
   import mood_link_pkg::*;
   localparam int unsigned OFF_C = 200;
   localparam int unsigned LAT_C = 200;
   logic        clock;
   logic        reset_n;
   logic        near_dropout;
   logic        send_valid;
   logic [3:0]  send_setting;
   logic        send_ready;
   logic        send_done;
   logic        enabled;
   logic        pump_ready;
   pump_mode_t  pump_mode;
   logic        setting_valid;
   logic [3:0]  setting;
   mood_t       mood;
   logic        dimmed;
   logic        slow_pace;
   logic [5:0]  colour_index;
   logic [7:0]  cs_one;
   logic [7:0]  cs_two;
   logic [2:0]  led_rgb;
   int          bad_count;
   int          cmp_count;
   int unsigned lfsr_q;
   int          code_q[$];
   mood_link_if link ();
   // Burst phases last 125 cycles; latch and off counts stay above that
   mood_led_host #(.RESYNC_CYC(OFF_C + 64), .LATCH_CYC(LAT_C + 8)) u_mood_led_host (
      .clock(clock), .reset_n(reset_n), .link(link), .send_valid(send_valid),
      .send_setting(send_setting), .send_ready(send_ready), .send_done(send_done));
   mood_led_device #(.OFF_CYC(OFF_C), .LATCH_CYC(LAT_C), .SOFT_CYC(20), .FAST_CYC(4),
      .SLOW_CYC(8)) u_mood_led_device (.clock(clock), .reset_n(reset_n), .link(link),
      .near_dropout(near_dropout), .enabled(enabled), .pump_ready(pump_ready),
      .pump_mode(pump_mode), .setting_valid(setting_valid), .setting(setting),
      .mood(mood), .dimmed(dimmed), .slow_pace(slow_pace), .colour_index(colour_index),
      .current_source_one(cs_one), .current_source_two(cs_two), .led_rgb(led_rgb));
   mood_link_sva #(.OFF_CYC(OFF_C), .LATCH_CYC(LAT_C), .SOFT_CYC(20)) u_mood_link_sva (
      .clock(clock), .reset_n(reset_n), .enable_set(link.enable_set), .enabled(enabled),
      .pump_ready(pump_ready), .pump_mode(pump_mode), .setting_valid(setting_valid),
      .setting(setting), .mood(mood), .dimmed(dimmed), .slow_pace(slow_pace),
      .colour_index(colour_index), .current_source_one(cs_one),
      .current_source_two(cs_two));
   function automatic int unsigned lfsr(input int unsigned s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic send(input logic [3:0] code);
      int n;
      int s;
      int steps;
      logic near;
      logic [5:0] ci;
      lfsr_q = lfsr(lfsr_q);
      near = lfsr_q[5];
      for (n = 0; n < 16 && send_ready !== 1'b1; n++) @(negedge clock);
      @(posedge clock);
      send_valid <= 1'b1;
      send_setting <= code;
      near_dropout <= near;
      code_q.push_back(code + 1);
      @(posedge clock);
      send_valid <= 1'b0;
      repeat (OFF_C + 8) @(negedge clock);
      check("enabled", 0, enabled);
      check("setting_valid", 0, setting_valid);
      check("current_source_one", 0, cs_one);
      check("led_rgb", 0, led_rgb);
      for (n = 0; n < 5000 && send_done !== 1'b1; n++) @(negedge clock);
      n = code_q.pop_front();
      s = n - 1;
      check("setting_valid", 1, setting_valid);
      check("setting", s, setting);
      check("dimmed", s / 8, dimmed);
      check("slow_pace", (s / 4) % 2, slow_pace);
      check("mood", s % 4, mood);
      check("current_source_one", (s / 8) ? 8'hff >> 1 : 8'hff, cs_one);
      check("current_source_two", (s / 8) ? 8'hff >> 1 : 8'hff, cs_two);
      check("led_on", 1, led_rgb != 3'h0);
      check("pump_ready", 1, pump_ready);
      check("pump", 1, near ? pump_mode != pump_1x : pump_mode == pump_1x);
      steps = 0;
      ci = colour_index;
      repeat (64) begin
         @(negedge clock);
         if (colour_index !== ci) steps++;
         ci = colour_index;
      end
      s = (s / 4) % 2 ? 8 : 16;
      check("pace", 1, steps >= s - 1 && steps <= s + 1);
      check("held", 1, setting_valid);
      $display("test with %0d edges done", n);
   endtask
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      #(4 * 100000);
      bad_count++;
      $display("Error watchdog expected done seen hang");
      close_out();
   end
   initial begin
      reset_n = 1'b0;
      near_dropout = 1'b0;
      send_valid = 1'b0;
      send_setting = 4'h0;
      bad_count = 0;
      cmp_count = 0;
      lfsr_q = 91189;
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      @(negedge clock);
      check("enabled", 0, enabled);
      check("pump", pump_1x, pump_mode);
      for (int i = 0; i < 16; i++) send(i[3:0]);
      for (int i = 0; i < 4; i++) begin
         lfsr_q = lfsr(lfsr_q);
         send(lfsr_q[3:0]);
      end
      close_out();
   end
endmodule
`default_nettype wire
